// File: cagc_pkg.sv
// Purpose: Shared constants and types for the cell gain-control and driver status registers.
// Assumes: APB with 32-bit data; registers sit at four times their index.
// Notes: Times are in milliseconds and become cycles through the cycles-per-ms figure.
package cagc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_AGC_CTRL = 8'h24;
	localparam logic [7:0] IDX_DRV_STAT = 8'h25;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h26;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h27;
	localparam logic [11:0] ADDR_AGC_CTRL = {2'h0, IDX_AGC_CTRL, 2'h0};
	localparam logic [11:0] ADDR_DRV_STAT = {2'h0, IDX_DRV_STAT, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
	// Field positions of the gain-control register.
	localparam int NF_BIT = 14;
	localparam int NL_LSB = 11;
	localparam int HYS_LSB = 9;
	localparam int CLIP_BIT = 8;
	localparam int TG_LSB = 5;
	localparam int TC_LSB = 1;
	localparam int EN_BIT = 0;
	// Field positions of the driver status register.
	localparam int DRV_LSB = 10;
	localparam int POP_SEQUENCE_DISABLE_BIT = 5;
	localparam int PST_BIT = 4;
	localparam int NUM_DRV = 6;
	// Interrupt bits.
	localparam int IRQ_W = 3;
	localparam int IRQ_NOISE = 0;
	localparam int IRQ_POP = 1;
	localparam int IRQ_DRV = 2;
	// Reset values.
	localparam logic [13:0] AGC_CTRL_RST = 14'h0000;
	localparam logic [5:0] DRV_FLAG_RST = 6'h3f;
	localparam logic [8:0] SYNC_RST = {3'h0, DRV_FLAG_RST};
	// Timing.
	localparam int CLK_MHZ = 100;
	localparam int CYC_PER_MS_DEF = CLK_MHZ * 1000;
	localparam int POP_SHORT_MS = 802;
	localparam int POP_LONG_MS = 4006;
	localparam int POP_DC_MS = 1;
	localparam int ATK_MS_0 = 8;
	localparam int ATK_MS_1 = 11;
	localparam int ATK_MS_2 = 16;
	localparam int ATK_MS_3 = 20;
	localparam int DCY_MS_Z = 10;
	localparam int DCY_MS_0 = 100;
	localparam int DCY_MS_1 = 200;
	localparam int DCY_MS_2 = 400;
	localparam int DCY_MS_3 = 500;

	typedef struct packed {
		logic [2:0] noise_thr;
		logic [1:0] hyst;
		logic clip_en;
		logic [2:0] target;
		logic [3:0] time_const;
		logic agc_en;
	} cagc_cfg_t;

	typedef enum logic [1:0] {
		POP_IDLE = 2'h0,
		POP_RUN = 2'h1,
		POP_DONE = 2'h3
	} cagc_pop_state_t;
endpackage : cagc_pkg

// File: cagc_regs.sv
// Purpose: Cell gain-control configuration and driver power-down status registers on APB.
// Assumes: Status pins are asynchronous; pop_request comes from logic on pclk.
// Notes: Zero wait states; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
module cagc_regs #(
	parameter int CYC_PER_MS = cagc_pkg::CYC_PER_MS_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic noise_below_pin,
	input wire logic [5:0] driver_off_pin,
	input wire logic short_circuit_pin,
	input wire logic cap_mode_pin,
	input wire logic pop_request,
	output cagc_pkg::cagc_cfg_t agc_cfg,
	output logic signed [7:0] noise_threshold_db,
	output logic [2:0] hysteresis_db,
	output logic signed [7:0] target_half_db,
	output logic [31:0] attack_cycles,
	output logic [31:0] decay_cycles,
	output logic threshold_invalid,
	output logic driver_status_valid,
	output logic pop_active,
	output logic pop_done,
	output logic irq
);
	localparam int DCY_Z_CYC = cagc_pkg::DCY_MS_Z * CYC_PER_MS;
	localparam logic [31:0] POP_SHORT_CYC = 32'(cagc_pkg::POP_SHORT_MS * CYC_PER_MS);
	localparam logic [31:0] POP_LONG_CYC = 32'(cagc_pkg::POP_LONG_MS * CYC_PER_MS);
	localparam logic [31:0] POP_DC_CYC = 32'(cagc_pkg::POP_DC_MS * CYC_PER_MS);

	// Counters are 32 bits, so the longest pop time must fit.
	if (CYC_PER_MS < 1 || CYC_PER_MS > 1000000)
	begin : g_bad_rate
		$error("CYC_PER_MS out of range");
	end

	cagc_pkg::cagc_cfg_t cfg_reg;
	logic pop_sequence_disable_dis_reg;
	logic pst_long_reg;
	logic [8:0] s1_reg;
	logic [8:0] s2_reg;
	logic [8:0] s3_reg;
	logic [8:0] filt_reg;
	logic [8:0] filt_next;
	logic [5:0] drv_prev_reg;
	logic noise_prev_reg;
	logic noise_flag;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	logic [31:0] prdata_reg;
	logic [31:0] rd_data;
	cagc_pkg::cagc_pop_state_t pop_state_reg;
	logic [31:0] pop_cnt_reg;
	logic addr_hit;
	logic wr_en;
	logic setup;

	// Bus decode; the slave never inserts wait states.
	always_comb
	begin
		addr_hit = (paddr == cagc_pkg::ADDR_AGC_CTRL) || (paddr == cagc_pkg::ADDR_DRV_STAT) ||
			(paddr == cagc_pkg::ADDR_IRQ_STAT) || (paddr == cagc_pkg::ADDR_IRQ_MASK);
		setup = psel && !penable;
		wr_en = psel && penable && pwrite && addr_hit;
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata = prdata_reg;

	// Status pins pass three flops; a bit moves once the second and third agree.
	always_comb
	begin
		filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= cagc_pkg::SYNC_RST;
			s2_reg <= cagc_pkg::SYNC_RST;
			s3_reg <= cagc_pkg::SYNC_RST;
			filt_reg <= cagc_pkg::SYNC_RST;
		end
		else
		begin
			s1_reg <= {short_circuit_pin, cap_mode_pin, noise_below_pin, driver_off_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	// The comparator result means nothing with gain control off, so it is masked.
	assign noise_flag = filt_reg[6] && cfg_reg.agc_en;
	assign driver_status_valid = !filt_reg[8];

	// Configuration writes; read-only positions of the written word are dropped.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg <= cagc_pkg::AGC_CTRL_RST;
			pop_sequence_disable_dis_reg <= 1'b0;
			pst_long_reg <= 1'b0;
			irq_mask_reg <= 3'h0;
		end
		else if (wr_en)
		begin
			if (paddr == cagc_pkg::ADDR_AGC_CTRL)
			begin
				cfg_reg <= pwdata[cagc_pkg::NF_BIT-1:0];
			end
			if (paddr == cagc_pkg::ADDR_DRV_STAT)
			begin
				pop_sequence_disable_dis_reg <= pwdata[cagc_pkg::POP_SEQUENCE_DISABLE_BIT];
				pst_long_reg <= pwdata[cagc_pkg::PST_BIT];
			end
			if (paddr == cagc_pkg::ADDR_IRQ_MASK)
			begin
				irq_mask_reg <= pwdata[cagc_pkg::IRQ_W-1:0];
			end
		end
	end
	assign agc_cfg = cfg_reg;

	// Read data is captured in the setup cycle, so the access phase returns a flop.
	always_comb
	begin
		rd_data = 32'h0;
		case (paddr)
			cagc_pkg::ADDR_AGC_CTRL:
			begin
				rd_data[cagc_pkg::NF_BIT] = noise_flag;
				rd_data[cagc_pkg::NF_BIT-1:0] = cfg_reg;
			end
			cagc_pkg::ADDR_DRV_STAT:
			begin
				rd_data[cagc_pkg::DRV_LSB+5:cagc_pkg::DRV_LSB] = filt_reg[5:0];
				rd_data[cagc_pkg::POP_SEQUENCE_DISABLE_BIT] = pop_sequence_disable_dis_reg;
				rd_data[cagc_pkg::PST_BIT] = pst_long_reg;
			end
			cagc_pkg::ADDR_IRQ_STAT: rd_data[2:0] = irq_stat_reg;
			cagc_pkg::ADDR_IRQ_MASK: rd_data[2:0] = irq_mask_reg;
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0;
		else if (setup && !pwrite)
			prdata_reg <= rd_data;
	end

	// Decoded settings for the gain-control datapath.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			noise_threshold_db <= 8'he2;
			hysteresis_db <= 3'h1;
			target_half_db <= 8'hf5;
			attack_cycles <= 32'(cagc_pkg::ATK_MS_0 * CYC_PER_MS);
			decay_cycles <= 32'(DCY_Z_CYC);
			threshold_invalid <= 1'b0;
		end
		else
		begin
			case (cfg_reg.noise_thr)
				3'h0, 3'h1: noise_threshold_db <= 8'he2;
				3'h2: noise_threshold_db <= 8'hd8;
				3'h3: noise_threshold_db <= 8'hce;
				3'h4: noise_threshold_db <= 8'hc4;
				3'h5: noise_threshold_db <= 8'hba;
				3'h6: noise_threshold_db <= 8'hb0;
				default: noise_threshold_db <= 8'ha6;
			endcase
			// With gain control on, codes above 100 are flagged for the cell path rather than clamped.
			threshold_invalid <= cfg_reg.agc_en && (cfg_reg.noise_thr > 3'h4);
			case (cfg_reg.hyst)
				2'h0: hysteresis_db <= 3'h1;
				2'h1: hysteresis_db <= 3'h2;
				2'h2: hysteresis_db <= 3'h4;
				default: hysteresis_db <= 3'h0;
			endcase
			case (cfg_reg.target)
				3'h0: target_half_db <= 8'hf5;
				3'h1: target_half_db <= 8'hf0;
				3'h2: target_half_db <= 8'hec;
				3'h3: target_half_db <= 8'he8;
				3'h4: target_half_db <= 8'he4;
				3'h5: target_half_db <= 8'hde;
				3'h6: target_half_db <= 8'hd8;
				default: target_half_db <= 8'hd0;
			endcase
			// Counts run on pclk, so they do not move with the audio sample rate.
			case (cfg_reg.time_const[1:0])
				2'h0: attack_cycles <= 32'(cagc_pkg::ATK_MS_0 * CYC_PER_MS);
				2'h1: attack_cycles <= 32'(cagc_pkg::ATK_MS_1 * CYC_PER_MS);
				2'h2: attack_cycles <= 32'(cagc_pkg::ATK_MS_2 * CYC_PER_MS);
				default: attack_cycles <= 32'(cagc_pkg::ATK_MS_3 * CYC_PER_MS);
			endcase
			if (cfg_reg.time_const == 4'h0)
				decay_cycles <= 32'(DCY_Z_CYC);
			else
			begin
				case (cfg_reg.time_const[3:2])
					2'h0: decay_cycles <= 32'(cagc_pkg::DCY_MS_0 * CYC_PER_MS);
					2'h1: decay_cycles <= 32'(cagc_pkg::DCY_MS_1 * CYC_PER_MS);
					2'h2: decay_cycles <= 32'(cagc_pkg::DCY_MS_2 * CYC_PER_MS);
					default: decay_cycles <= 32'(cagc_pkg::DCY_MS_3 * CYC_PER_MS);
				endcase
			end
		end
	end

	// Pop sequencer; timing is latched at start so a later write cannot stretch it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pop_state_reg <= cagc_pkg::POP_IDLE;
			pop_cnt_reg <= 32'h0;
		end
		else
		begin
			case (pop_state_reg)
				cagc_pkg::POP_IDLE:
				begin
					if (pop_request)
					begin
						if (pop_sequence_disable_dis_reg)
							pop_state_reg <= cagc_pkg::POP_DONE;
						else
						begin
							pop_state_reg <= cagc_pkg::POP_RUN;
							if (!filt_reg[7])
								pop_cnt_reg <= POP_DC_CYC;
							else if (pst_long_reg)
								pop_cnt_reg <= POP_LONG_CYC;
							else
								pop_cnt_reg <= POP_SHORT_CYC;
						end
					end
				end
				cagc_pkg::POP_RUN:
				begin
					pop_cnt_reg <= pop_cnt_reg - 32'h1;
					if (pop_cnt_reg <= 32'h1)
						pop_state_reg <= cagc_pkg::POP_DONE;
				end
				cagc_pkg::POP_DONE: pop_state_reg <= cagc_pkg::POP_IDLE;
				default: pop_state_reg <= cagc_pkg::POP_IDLE;
			endcase
		end
	end
	assign pop_active = (pop_state_reg == cagc_pkg::POP_RUN);
	assign pop_done = (pop_state_reg == cagc_pkg::POP_DONE);

	// Sticky interrupt status; a new event beats a write-one clear in the same cycle.
	always_comb
	begin
		irq_ev = 3'h0;
		irq_ev[cagc_pkg::IRQ_NOISE] = noise_flag && !noise_prev_reg;
		irq_ev[cagc_pkg::IRQ_POP] = pop_done;
		irq_ev[cagc_pkg::IRQ_DRV] = (filt_reg[5:0] != drv_prev_reg);
		irq_clr = (wr_en && paddr == cagc_pkg::ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_reg <= 3'h0;
			noise_prev_reg <= 1'b0;
			drv_prev_reg <= cagc_pkg::DRV_FLAG_RST;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
			noise_prev_reg <= noise_flag;
			drv_prev_reg <= filt_reg[5:0];
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_pop_long;
		pop_state_reg == cagc_pkg::POP_IDLE && pop_request && !pop_sequence_disable_dis_reg &&
			filt_reg[7] && pst_long_reg;
	endsequence
	sequence s_pop_skip;
		pop_state_reg == cagc_pkg::POP_IDLE && pop_request && pop_sequence_disable_dis_reg;
	endsequence

	chk_noise_gate: assert property (setup && !pwrite && paddr == cagc_pkg::ADDR_AGC_CTRL
		&& !cfg_reg.agc_en |=> !prdata[cagc_pkg::NF_BIT])
		else $error("noise flag read with gain control off");
	chk_thr_decode: assert property (cfg_reg.noise_thr == 3'h1 |=> noise_threshold_db == 8'he2)
		else $error("threshold code 001 not -30 dB");
	chk_hyst_none: assert property (cfg_reg.hyst == 2'h3 |=> hysteresis_db == 3'h0)
		else $error("hysteresis not removed");
	chk_target_top: assert property (cfg_reg.target == 3'h7 |=> target_half_db == 8'hd0)
		else $error("target code 111 not -24 dB");
	chk_decay_short: assert property (cfg_reg.time_const == 4'h0 |=> decay_cycles == 32'(DCY_Z_CYC))
		else $error("decay for code 0000 wrong");
	chk_enable_write: assert property (wr_en && paddr == cagc_pkg::ADDR_AGC_CTRL
		|=> cfg_reg.agc_en == $past(pwdata[0]) && cfg_reg.clip_en == $past(pwdata[8]))
		else $error("enable bits did not take write");
	chk_flag_read: assert property (setup && !pwrite && paddr == cagc_pkg::ADDR_DRV_STAT
		|=> prdata[15:10] == $past(filt_reg[5:0]) && prdata[9:6] == 4'h0)
		else $error("driver flags read wrong");
	chk_sc_valid: assert property (filt_reg[8] |-> !driver_status_valid)
		else $error("flags valid during short circuit");
	chk_pop_skip: assert property (s_pop_skip |=> pop_done ##1 !pop_done)
		else $error("disabled pop sequence not skipped");
	chk_pop_long: assert property (s_pop_long |=> pop_active && pop_cnt_reg == POP_LONG_CYC)
		else $error("long pop sequence not loaded");
	chk_pop_count: assert property (pop_active && pop_cnt_reg > 32'h1
		|=> pop_active && pop_cnt_reg == $past(pop_cnt_reg) - 32'h1)
		else $error("pop counter not counting down");
	chk_ro_flag: assert property (setup && !pwrite && paddr == cagc_pkg::ADDR_AGC_CTRL
		|=> prdata[15] == 1'b0 && prdata[14] == $past(noise_flag))
		else $error("read-only noise position wrong");
	chk_irq_sticky: assert property (irq_ev[cagc_pkg::IRQ_POP] |=> irq_stat_reg[cagc_pkg::IRQ_POP])
		else $error("pop event lost");
endmodule : cagc_regs

// File: cagc_regs_tb_top.sv
// Purpose: Self-checking bench for the cell gain-control and driver status registers.
// Assumes: APB master drives by non-blocking assignment just after each rising edge.
// Notes: CYC_PER_MS is cut to 10 so the long pop sequences stay within the run budget.
`timescale 1ns/1ps
module cagc_regs_tb_top;
	localparam int CPM = 10;
	typedef struct packed {
		logic [15:0] wr;
		logic [7:0] thr;
		logic [2:0] hys;
		logic [7:0] tgt;
		logic [7:0] atk;
		logic [9:0] dcy;
		logic inv;
	} cagc_row_t;
	cagc_row_t rows [8] = '{
		'{16'h4000, 8'he2, 3'h1, 8'hf5, 8'h08, 10'h00a, 1'h0},
		'{16'h0b23, 8'he2, 3'h2, 8'hf0, 8'h0b, 10'h064, 1'h0},
		'{16'h144c, 8'hd8, 3'h4, 8'hec, 8'h10, 10'h0c8, 1'h0},
		'{16'h1f77, 8'hce, 3'h0, 8'he8, 8'h14, 10'h190, 1'h0},
		'{16'h2099, 8'hc4, 3'h1, 8'he4, 8'h08, 10'h1f4, 1'h0},
		'{16'h2bbf, 8'hba, 3'h2, 8'hde, 8'h14, 10'h1f4, 1'h1},
		'{16'h34c5, 8'hb0, 3'h4, 8'hd8, 8'h10, 10'h064, 1'h1},
		'{16'h3feb, 8'ha6, 3'h0, 8'hd0, 8'h0b, 10'h0c8, 1'h1}
	};
	logic [1:0] pop_pins [3] = '{2'h0, 2'h2, 2'h3};
	int pop_len [3] = '{CPM * 1, CPM * 802, CPM * 4006};
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err;
	logic noise_below_pin, short_circuit_pin, cap_mode_pin, pop_request;
	logic [5:0] driver_off_pin;
	cagc_pkg::cagc_cfg_t agc_cfg;
	logic signed [7:0] noise_threshold_db, target_half_db;
	logic [2:0] hysteresis_db;
	logic [31:0] attack_cycles, decay_cycles;
	logic threshold_invalid, driver_status_valid, pop_active, pop_done, irq;
	int n_fail = 0;
	int checked = 0;
	int n;

	cagc_regs #(.CYC_PER_MS(CPM)) u_cagc_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .noise_below_pin(noise_below_pin),
		.driver_off_pin(driver_off_pin), .short_circuit_pin(short_circuit_pin),
		.cap_mode_pin(cap_mode_pin), .pop_request(pop_request), .agc_cfg(agc_cfg),
		.noise_threshold_db(noise_threshold_db), .hysteresis_db(hysteresis_db),
		.target_half_db(target_half_db), .attack_cycles(attack_cycles),
		.decay_cycles(decay_cycles), .threshold_invalid(threshold_invalid),
		.driver_status_valid(driver_status_valid), .pop_active(pop_active),
		.pop_done(pop_done), .irq(irq));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// A slave that never answers is left to the watchdog, which ends the run.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic settle(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask : settle

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	initial
	begin
		#1ms;
		n_fail++;
		give_verdict();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		noise_below_pin = 1'b0;
		short_circuit_pin = 1'b0;
		cap_mode_pin = 1'b0;
		pop_request = 1'b0;
		driver_off_pin = 6'h3f;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		chk("rst thr", {24'h0, noise_threshold_db}, 32'he2);
		chk("rst tgt", {24'h0, target_half_db}, 32'hf5);
		chk("rst irq", {31'h0, irq}, 32'h0);
		apb(1'b0, cagc_pkg::ADDR_AGC_CTRL, 32'h0);
		chk("rst ctrl", rd, 32'h0);
		apb(1'b0, cagc_pkg::ADDR_DRV_STAT, 32'h0);
		chk("rst drv", rd, 32'hfc00);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, cagc_pkg::ADDR_AGC_CTRL, {16'h0, rows[i].wr});
			settle(2);
			chk("cfg", {18'h0, agc_cfg}, {18'h0, rows[i].wr[13:0]});
			chk("thr", {24'h0, noise_threshold_db}, {24'h0, rows[i].thr});
			chk("hys", {29'h0, hysteresis_db}, {29'h0, rows[i].hys});
			chk("tgt", {24'h0, target_half_db}, {24'h0, rows[i].tgt});
			chk("atk", attack_cycles, {24'h0, rows[i].atk} * CPM);
			chk("dcy", decay_cycles, {22'h0, rows[i].dcy} * CPM);
			chk("inv", {31'h0, threshold_invalid}, {31'h0, rows[i].inv});
			apb(1'b0, cagc_pkg::ADDR_AGC_CTRL, 32'h0);
			chk("ctrl rd", rd, {16'h0, rows[i].wr & 16'h3fff});
		end
		apb(1'b1, cagc_pkg::ADDR_IRQ_STAT, 32'h7);
		apb(1'b1, cagc_pkg::ADDR_IRQ_MASK, 32'h0);
		noise_below_pin <= 1'b1;
		settle(5);
		apb(1'b0, cagc_pkg::ADDR_AGC_CTRL, 32'h0);
		chk("noise flag", rd, 32'h7feb);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, cagc_pkg::ADDR_IRQ_MASK, 32'h1);
		settle(2);
		chk("irq noise", {31'h0, irq}, 32'h1);
		apb(1'b1, cagc_pkg::ADDR_IRQ_STAT, 32'h1);
		settle(2);
		chk("irq clear", {31'h0, irq}, 32'h0);
		apb(1'b1, cagc_pkg::ADDR_AGC_CTRL, 32'h3fea);
		apb(1'b0, cagc_pkg::ADDR_AGC_CTRL, 32'h0);
		chk("noise off", rd, 32'h3fea);
		noise_below_pin <= 1'b0;
		driver_off_pin <= 6'h15;
		apb(1'b1, cagc_pkg::ADDR_IRQ_MASK, 32'h4);
		settle(5);
		chk("irq drv", {31'h0, irq}, 32'h1);
		apb(1'b1, cagc_pkg::ADDR_DRV_STAT, 32'h0000fc30);
		apb(1'b0, cagc_pkg::ADDR_DRV_STAT, 32'h0);
		chk("drv rd", rd, 32'h5430);
		short_circuit_pin <= 1'b1;
		settle(5);
		chk("short", {31'h0, driver_status_valid}, 32'h0);
		@(posedge pclk);
		short_circuit_pin <= 1'b0;
		settle(5);
		chk("no short", {31'h0, driver_status_valid}, 32'h1);
		apb(1'b1, 12'h100, 32'h1);
		chk("unmapped wr", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped rd", rd, 32'h0);
		for (int p = -1; p < 3; p++)
		begin
			// Row -1 runs with pop sequencing disabled, so it must finish at once.
			apb(1'b1, cagc_pkg::ADDR_DRV_STAT, p < 0 ? 32'h20 : {27'h0, pop_pins[p][0], 4'h0});
			apb(1'b1, cagc_pkg::ADDR_IRQ_STAT, 32'h7);
			apb(1'b1, cagc_pkg::ADDR_IRQ_MASK, 32'h2);
			cap_mode_pin <= p < 0 ? 1'b0 : pop_pins[p][1];
			settle(5);
			@(posedge pclk);
			pop_request <= 1'b1;
			@(posedge pclk);
			pop_request <= 1'b0;
			#1;
			n = 0;
			for (int i = 0; i < 50000 && pop_done !== 1'b1; i++)
			begin
				if (pop_active === 1'b1)
					n++;
				settle(1);
			end
			chk("pop len", 32'(n), p < 0 ? 32'h0 : 32'(pop_len[p]));
			settle(1);
			chk("pop pulse", {31'h0, pop_done}, 32'h0);
			chk("irq pop", {31'h0, irq}, 32'h1);
		end
		// A reset in mid-run must drop the configuration and interrupt state.
		@(posedge pclk);
		presetn <= 1'b0;
		settle(2);
		chk("mid rst irq", {31'h0, irq}, 32'h0);
		chk("mid rst thr", {24'h0, noise_threshold_db}, 32'he2);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cagc_pkg::ADDR_AGC_CTRL, 32'h0);
		chk("mid rst ctrl", rd, 32'h0);
		give_verdict();
	end
endmodule : cagc_regs_tb_top
